// ### design/usr_pkg.sv
`default_nettype none
package usr_pkg;

  // ----------------------------------------------------------------
  // Geometry, modes and buffering
  // ----------------------------------------------------------------
  localparam int unsigned NUM_STAGES = 4;
  localparam int unsigned SNAP_DEPTH = 4;
  localparam int unsigned FILL_W     = 3;

  localparam logic              MODE_SHIFT = 1'b0;
  localparam logic              MODE_LOAD  = 1'b1;
  localparam logic [FILL_W-1:0] FILL_ZERO  = 3'h0;
  localparam logic [FILL_W-1:0] FILL_FULL  = 3'h4;
  localparam logic [FILL_W-1:0] FILL_ONE   = 3'h1;

  typedef logic [NUM_STAGES-1:0] usr_stages_t;

  // Index 0 is the first stage, index NUM_STAGES-1 the last stage.
  typedef struct packed {
    usr_stages_t         stages;
    logic                shift_prev;
    logic                load_prev;
    logic                pend_valid;
    usr_stages_t         pend_data;
    logic [FILL_W-1:0]   fill_cnt;
    logic                known;
    logic                snap_drop;
  } usr_core_t;

endpackage : usr_pkg
`default_nettype wire

// ### design/usr_fifo.sv
`default_nettype none
module usr_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  initial begin
    if (WIDTH < 1 || DEPTH < 2) begin
      $error("usr_fifo needs WIDTH >= 1 and DEPTH >= 2");
    end
  end

  // ----------------------------------------------------------------
  // State: head at index 0, so both output ports leave a flip-flop.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
  } usr_fifo_st_t;

  usr_fifo_st_t st_r;
  usr_fifo_st_t st_nxt;

  assign in_ready  = !st_r.vld[DEPTH-1];
  assign out_valid = st_r.vld[0];
  assign out_data  = st_r.mem[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    st_nxt = st_r;
    if (st_r.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_nxt.mem[i] = st_r.mem[i+1];
        st_nxt.vld[i] = st_r.vld[i+1];
      end
      st_nxt.vld[DEPTH-1] = 1'b0;
    end
    // A full FIFO refuses a push even if it pops; that keeps ready off the pop path.
    if (in_valid && in_ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !st_nxt.vld[i]) begin
          st_nxt.mem[i] = in_data;
          st_nxt.vld[i] = 1'b1;
          placed        = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // usr_fifo
`default_nettype wire

// ### design/usr_shift_reg.sv
`default_nettype none
// Operation
// RL1 - Four stages, each driving its own output, all four always visible.
// RL2 - Mode low: each shift clock edge enters serial bit, moves stages toward last.
// RL3 - Mode low: load clock and parallel inputs cannot change the stages.
// RL4 - Mode high: each load clock edge copies four parallel inputs into stages.
// RL5 - Outside logic builds left shift by feeding outputs back in parallel mode.
// RL6 - Contents change only on the falling edge of the active clock.
// RL7 - No reset of contents; they are unknown until all four stages are written. Here reset clears the stages to 0.
module usr_shift_reg
  import usr_pkg::*;
#(
  parameter int unsigned STAGES = usr_pkg::NUM_STAGES,
  parameter int unsigned DEPTH  = usr_pkg::SNAP_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                mode_sel,
  input  wire logic                shift_clk,
  input  wire logic                load_clk,
  input  wire logic                serial_in,
  input  wire usr_pkg::usr_stages_t parallel_in,
  output var        usr_pkg::usr_stages_t stage_out,
  output logic                     contents_known,
  output logic                     snap_drop,
  output logic                     snap_valid,
  input  wire logic                snap_ready,
  output var        usr_pkg::usr_stages_t snap_data
);
  import usr_pkg::*;

  initial begin
    if (STAGES != NUM_STAGES || DEPTH < 2) begin
      $error("usr_shift_reg serves exactly the packaged stage count and DEPTH >= 2");
    end
  end

  // ----------------------------------------------------------------
  // Next contents of the stages for one clock event.
  // ----------------------------------------------------------------
  function automatic usr_stages_t next_stages(input logic        mode,
                                              input usr_stages_t cur,
                                              input logic        ser,
                                              input usr_stages_t par);
    usr_stages_t res;
    if (mode == MODE_LOAD) begin
      res = par; // RL4
    end else begin
      res = {cur[NUM_STAGES-2:0], ser}; // RL2
    end
    return res;
  endfunction

  usr_core_t st_r;
  usr_core_t st_nxt;

  logic shift_fall;
  logic load_fall;
  logic ev;
  logic fifo_in_ready;

  assign shift_fall = st_r.shift_prev && !shift_clk;
  assign load_fall  = st_r.load_prev && !load_clk;
  // Each mode listens to its own clock only, the other clock is inhibited.
  assign ev = (mode_sel == MODE_SHIFT) ? shift_fall : load_fall; // RL3 RL6

  // ----------------------------------------------------------------
  // Core update
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    st_nxt.shift_prev = shift_clk;
    st_nxt.load_prev  = load_clk;
    st_nxt.snap_drop  = 1'b0;
    if (st_r.pend_valid && fifo_in_ready) begin
      st_nxt.pend_valid = 1'b0;
    end
    if (ev) begin
      st_nxt.stages = next_stages(mode_sel, st_r.stages, serial_in, parallel_in); // RL6
      // The register never waits for the FIFO; a snapshot still waiting is replaced.
      st_nxt.snap_drop  = st_r.pend_valid && !fifo_in_ready;
      st_nxt.pend_valid = 1'b1;
      st_nxt.pend_data  = st_nxt.stages;
      if (mode_sel == MODE_LOAD) begin
        st_nxt.fill_cnt = FILL_FULL; // RL7
      end else if (st_r.fill_cnt != FILL_FULL) begin
        st_nxt.fill_cnt = st_r.fill_cnt + FILL_ONE; // RL7
      end
    end
    st_nxt.known = (st_nxt.fill_cnt == FILL_FULL); // RL7
  end

  // Reset clears tracking and the stages alike; the stage values themselves carry no meaning
  // until contents_known rises.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stage_out      = st_r.stages; // RL1
  assign contents_known = st_r.known;
  assign snap_drop      = st_r.snap_drop;

  // ----------------------------------------------------------------
  // Snapshot stream of new stage values, less any replaced while still waiting
  // ----------------------------------------------------------------
  usr_fifo #(
    .WIDTH (NUM_STAGES),
    .DEPTH (DEPTH)
  ) u_snap_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (st_r.pend_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (st_r.pend_data),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (snap_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_new_value_visible;
    @(posedge core_clk) disable iff (!rst_n)
      ev |=> (st_r.pend_valid && st_r.pend_data == stage_out);
  endproperty
  a_new_value_visible: assert property (p_new_value_visible) // RL1
    else $error("new stage value not presented for snapshot");

  property p_shift_right;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_SHIFT && shift_fall) |=>
        stage_out == {$past(stage_out[NUM_STAGES-2:0]), $past(serial_in)};
  endproperty
  a_shift_right: assert property (p_shift_right) // RL2
    else $error("shift did not move stages with serial entry");

  property p_load_inhibited;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_SHIFT && !shift_fall) |=> $stable(stage_out);
  endproperty
  a_load_inhibited: assert property (p_load_inhibited) // RL3
    else $error("stages changed in shift mode without a shift edge");

  property p_parallel_load;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_LOAD && load_fall) |=>
        (stage_out == $past(parallel_in) && contents_known);
  endproperty
  a_parallel_load: assert property (p_parallel_load) // RL4
    else $error("parallel load did not copy inputs");

  property p_falling_only;
    @(posedge core_clk) disable iff (!rst_n)
      !$stable(stage_out) |-> $past(ev);
  endproperty
  a_falling_only: assert property (p_falling_only) // RL6
    else $error("stages changed without a falling clock edge");

  property p_known_cause;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(contents_known) |-> $past(ev);
  endproperty
  a_known_cause: assert property (p_known_cause) // RL7
    else $error("contents marked known without a write");

  // ----------------------------------------------------------------
  // Mode inhibit and fill tracking checks
  // ----------------------------------------------------------------
  property p_shift_ignored;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_LOAD && !load_fall) |=> $stable(stage_out);
  endproperty
  a_shift_ignored: assert property (p_shift_ignored) // RL4
    else $error("stages changed in load mode without a load edge");

  property p_known_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      contents_known |=> contents_known;
  endproperty
  a_known_sticky: assert property (p_known_sticky) // RL7
    else $error("contents fell back to unknown");

  // Fewer than four shifts since reset leave at least one stage unwritten.
  property p_early_unknown;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_SHIFT && shift_fall && st_r.fill_cnt < FILL_FULL - FILL_ONE) |=>
        !contents_known;
  endproperty
  a_early_unknown: assert property (p_early_unknown) // RL7
    else $error("contents marked known before four shifts");

  property p_fourth_shift_known;
    @(posedge core_clk) disable iff (!rst_n)
      (mode_sel == MODE_SHIFT && shift_fall && st_r.fill_cnt == FILL_FULL - FILL_ONE) |=>
        contents_known;
  endproperty
  a_fourth_shift_known: assert property (p_fourth_shift_known) // RL7
    else $error("fourth shift did not mark contents known");

  // ----------------------------------------------------------------
  // Snapshot stream checks
  // ----------------------------------------------------------------
  // A drop is only legal when a waiting snapshot is replaced by a newer one.
  property p_drop_cause;
    @(posedge core_clk) disable iff (!rst_n)
      snap_drop |-> ($past(ev) && $past(st_r.pend_valid) && !$past(fifo_in_ready));
  endproperty
  a_drop_cause: assert property (p_drop_cause) // RL1
    else $error("snapshot dropped although the buffer had room");

  property p_snap_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (snap_valid && !snap_ready) |=> (snap_valid && $stable(snap_data));
  endproperty
  a_snap_hold: assert property (p_snap_hold) // RL1
    else $error("stalled snapshot head changed or vanished");

  property p_pend_taken;
    @(posedge core_clk) disable iff (!rst_n)
      (st_r.pend_valid && fifo_in_ready) |=> snap_valid;
  endproperty
  a_pend_taken: assert property (p_pend_taken) // RL1
    else $error("accepted snapshot not offered to the consumer");

endmodule // usr_shift_reg
`default_nettype wire

// ### tb/usr_host_model.sv
`default_nettype none
module usr_host_model (
  input  wire logic                 core_clk,
  input  wire usr_pkg::usr_stages_t stage_out,
  output logic                      mode_sel,
  output logic                      shift_clk,
  output logic                      load_clk,
  output logic                      serial_in,
  output var usr_pkg::usr_stages_t  parallel_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import usr_pkg::*;

  initial begin
    mode_sel    = MODE_SHIFT;
    shift_clk   = 1'b0;
    load_clk    = 1'b0;
    serial_in   = 1'b0;
    parallel_in = 4'h0;
  end

  // ------------------------------------------------------------
  // One clock pulse: high for hi samples, then the falling edge
  // ------------------------------------------------------------
  task automatic ev(input logic m, input logic ld, input logic s, input usr_stages_t p,
                    input int hi);
    @(posedge core_clk);
    mode_sel    <= m;
    serial_in   <= s;
    parallel_in <= p;
    if (ld) begin
      load_clk <= 1'b1;
    end else begin
      shift_clk <= 1'b1;
    end
    repeat (hi) @(posedge core_clk);
    shift_clk <= 1'b0;
    load_clk  <= 1'b0;
    @(posedge core_clk);
    // Data past its hold time is inverted so a stale value never passes.
    serial_in   <= ~s;
    parallel_in <= ~p;
  endtask

  // Left shift needs the outputs fed back one stage down, in load mode.
  task automatic left(input logic s);
    ev(MODE_LOAD, 1'b1, 1'b0, {s, stage_out[3:1]}, 1);
  endtask
endmodule // usr_host_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import usr_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        snap_ready = 1'b0;
  logic        mode_sel, shift_clk, load_clk, serial_in;
  logic        contents_known, snap_drop, snap_valid;
  usr_stages_t parallel_in, stage_out, snap_data;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          drops      = 0;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (snap_drop === 1'b1) drops <= drops + 1;

  usr_shift_reg #(.STAGES(4), .DEPTH(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .mode_sel(mode_sel), .shift_clk(shift_clk), .load_clk(load_clk),
    .serial_in(serial_in), .parallel_in(parallel_in), .stage_out(stage_out),
    .contents_known(contents_known), .snap_drop(snap_drop), .snap_valid(snap_valid),
    .snap_ready(snap_ready), .snap_data(snap_data));
  usr_host_model host (.core_clk(core_clk), .stage_out(stage_out), .mode_sel(mode_sel),
    .shift_clk(shift_clk), .load_clk(load_clk), .serial_in(serial_in),
    .parallel_in(parallel_in));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Six shifts with the consumer stalled: four fill the buffer, the fifth waits
  // and is overwritten by the sixth.
  task automatic t_shift_fill();
    usr_stages_t ex [6] = '{4'h1, 4'h2, 4'h5, 4'hb, 4'h6, 4'hd};
    usr_stages_t got [5] = '{4'h1, 4'h2, 4'h5, 4'hb, 4'hd};
    for (int i = 0; i < 6; i++) begin
      host.ev(MODE_SHIFT, 1'b0, ex[i][0], ~ex[i], 1);
      #1;
      chk(stage_out, ex[i]);
      if (i == 2) chk(contents_known, 1'b0);
    end
    chk(contents_known, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(drops[7:0], 8'h01);
    snap_ready <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      repeat (20) if (snap_valid !== 1'b1) @(negedge core_clk);
      chk(snap_data, got[i]);
      @(posedge core_clk);
    end
    repeat (3) @(negedge core_clk);
    chk(snap_valid, 1'b0);
  endtask

  task automatic t_inhibit();
    host.ev(MODE_SHIFT, 1'b1, 1'b0, 4'h3, 1);
    #1;
    chk(stage_out, 4'hd);
    host.ev(MODE_LOAD, 1'b0, 1'b1, 4'h3, 1);
    #1;
    chk(stage_out, 4'hd);
    host.ev(MODE_LOAD, 1'b1, 1'b0, 4'ha, 1);
    #1;
    chk(stage_out, 4'ha);
    host.ev(MODE_LOAD, 1'b1, 1'b1, 4'h5, 1);
    #1;
    chk(stage_out, 4'h5);
  endtask

  // A long high phase must not move the stages before the fall.
  task automatic t_hold();
    fork
      host.ev(MODE_SHIFT, 1'b0, 1'b1, 4'h0, 5);
      begin
        repeat (5) @(posedge core_clk);
        #1;
        chk(stage_out, 4'h5);
      end
    join
    #1;
    chk(stage_out, 4'hb);
    host.left(1'b1);
    #1;
    chk(stage_out, 4'hd);
    host.left(1'b0);
    #1;
    chk(stage_out, 4'h6);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_shift_fill();
    t_inhibit();
    t_hold();
    give_verdict();
  end

  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
